// ===== verilog/wear_pkg.sv
// breaker wear monitor: shared widths, register map, timing and types
// assumes one 250 MHz system clock and a 32-bit plain register port
`default_nettype none
package wear_pkg;
  localparam int CUR_W = 20;
  localparam int CNT_W = 20;
  localparam int LOG_W = 16;
  localparam int NPOINT = 8;
  localparam int NCNT = 6;
  localparam int IRQ_W = 5;
  localparam int TICK_W = 22;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int SAMPLE_PERIOD_MS = 10;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int CAPTURE_WINDOW_MS = 500;
  localparam int CAPTURE_SAMPLES = CAPTURE_WINDOW_MS / SAMPLE_PERIOD_MS;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_AL1_CUR = 8'h04;
  localparam logic [7:0] A_AL1_LIM = 8'h08;
  localparam logic [7:0] A_AL2_CUR = 8'h0c;
  localparam logic [7:0] A_AL2_LIM = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_IRQ_STAT = 8'h18;
  localparam logic [7:0] A_IRQ_EN = 8'h1c;
  localparam logic [7:0] A_IRQ_CLR = 8'h20;
  localparam logic [7:0] A_TRIP_TIME = 8'h24;
  localparam logic [7:0] A_LAST_I = 8'h28;
  localparam logic [7:0] A_CYC_LEFT = 8'h40;
  localparam logic [7:0] A_CURVE = 8'h80;
  // fields
  localparam int CTRL_CLEAR_BIT = 8;
  localparam int IRQ_TRIP_BIT = 4;
  // reset values
  localparam logic [3:0] EV_EN_RST = 4'h0;
  localparam logic [CUR_W-1:0] CUR_RST = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 5'h00;

  typedef struct packed {
    logic [CUR_W-1:0] c;
    logic [CUR_W-1:0] b;
    logic [CUR_W-1:0] a;
  } phase_mag_s;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_EVAL = 3'b001,
    S_IDIV = 3'b010,
    S_IFIN = 3'b011,
    S_LOAD = 3'b100,
    S_RATIO = 3'b101,
    S_RDIV = 3'b110,
    S_RFIN = 3'b111
  } calc_state_e;
endpackage
`default_nettype wire

// ===== verilog/breaker_wear_function.sv
// breaker wear monitor: trip peak capture, curve lookup, wear counters,
// alarms, events and register port
// assumes phase magnitudes and time stamp come from logic on SYS_CLK_I
`default_nettype none
//
// Overview of operation
// - per trip, keep the peak magnitude of each phase as its breaking current
// - use fundamental magnitudes only; dc offset is already removed upstream
// - sample every 10 ms, starting when the trip output asserts
// - stop when all phases fall below quarter of peak, or after 500 ms
// - breaker curve holds eight points of current and permitted operations
// - interpolate as straight lines on log-log axes between curve points
// - operations equal a over I to the power n between points k, k+1
// - two alarm points, each with current and cycle limit
// - alarm when remaining cycles drop below that point's cycle limit
// - six counters, per phase per alarm; any phase raises the alarm
// - each alarm drives a signal into the output matrix
// - on and off events per alarm, each only when enabled
// - decrement by alarm-current operations over phase-current operations
// - phase current below alarm current decrements by exactly one
// - store latest trip time and breaking current of each phase
// - clear command resets all counters of both alarm points
module breaker_wear_function
  import wear_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYCLES
)
(
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic TRIP_I,
  input wire phase_mag_s PHASE_MAG_I,
  input wire logic [31:0] TIME_I,
  input wire logic UNLOCK_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic [1:0] ALARM_O,
  output logic [3:0] EVENT_O,
  output logic IRQ_O
);

  // ----------------------------------------
  // log helpers
  // ----------------------------------------
  // piecewise-linear log2, 5.11 fixed point; monotonic, which keeps
  // the interpolation fraction inside 0..1
  function automatic logic [LOG_W-1:0] log2f(input logic [CUR_W-1:0] x);
    logic [4:0] e;
    logic [CUR_W-1:0] m;
    e = 5'h00;
    for (int i = 0; i < CUR_W; i++)
    begin
      if (x[i])
        e = 5'(i);
    end
    m = x << (5'd19 - e);
    return {e, m[18:8]};
  endfunction

  function automatic logic [31:0] exp2f(input logic [LOG_W-1:0] l);
    logic [31:0] v;
    v = {20'h00000, 1'b1, l[10:0]} << l[15:11];
    return v >> 11;
  endfunction

  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [3:0] ev_en;
  logic [CUR_W-1:0] alarm_cur [2];
  logic [CNT_W-1:0] alarm_lim [2];
  logic [CUR_W-1:0] curve_i [NPOINT];
  logic [CNT_W-1:0] curve_c [NPOINT];
  logic [IRQ_W-1:0] irq_en;
  logic clear_cmd;
  logic set_wr;

  assign set_wr = WR_I & UNLOCK_I;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      ev_en <= EV_EN_RST;
      irq_en <= IRQ_EN_RST;
      clear_cmd <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        alarm_cur[i] <= CUR_RST;
        alarm_lim[i] <= CNT_RST;
      end
      for (int k = 0; k < NPOINT; k++)
      begin
        curve_i[k] <= CUR_RST;
        curve_c[k] <= CNT_RST;
      end
    end
    else
    begin
      clear_cmd <= set_wr && ADDR_I == A_CTRL && WDATA_I[CTRL_CLEAR_BIT];
      if (WR_I && ADDR_I == A_IRQ_EN)
        irq_en <= WDATA_I[IRQ_W-1:0];
      if (set_wr)
      begin
        case (ADDR_I)
          A_CTRL: ev_en <= WDATA_I[3:0];
          A_AL1_CUR: alarm_cur[0] <= WDATA_I[CUR_W-1:0];
          A_AL1_LIM: alarm_lim[0] <= WDATA_I[CNT_W-1:0];
          A_AL2_CUR: alarm_cur[1] <= WDATA_I[CUR_W-1:0];
          A_AL2_LIM: alarm_lim[1] <= WDATA_I[CNT_W-1:0];
          default:
          begin
            if (ADDR_I[7:6] == A_CURVE[7:6] && ADDR_I[1:0] == 2'b00)
            begin
              if (ADDR_I[2])
                curve_c[ADDR_I[5:3]] <= WDATA_I[CNT_W-1:0];
              else
                curve_i[ADDR_I[5:3]] <= WDATA_I[CUR_W-1:0];
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // trip input and peak capture
  // ----------------------------------------
  logic trip_s1;
  logic trip_s2;
  logic trip_d;
  logic cap_busy;
  logic cap_done;
  logic [TICK_W-1:0] tick;
  logic [5:0] nsamp;
  logic [CUR_W-1:0] mag [3];
  logic [CUR_W-1:0] peak [3];
  logic [CUR_W-1:0] next_peak [3];
  logic [2:0] low;
  logic [CUR_W-1:0] last_i [3];
  logic [31:0] trip_time;

  // front end delivers fundamental magnitudes, so no dc term reaches here
  assign mag[0] = PHASE_MAG_I.a;
  assign mag[1] = PHASE_MAG_I.b;
  assign mag[2] = PHASE_MAG_I.c;

  generate
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
      assign next_peak[p] = (mag[p] > peak[p]) ? mag[p] : peak[p];
      assign low[p] = {mag[p], 2'b00} < {2'b00, next_peak[p]};
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      trip_s1 <= 1'b0;
      trip_s2 <= 1'b0;
      trip_d <= 1'b0;
    end
    else
    begin
      trip_s1 <= TRIP_I;
      trip_s2 <= trip_s1;
      trip_d <= trip_s2;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      cap_busy <= 1'b0;
      cap_done <= 1'b0;
      tick <= '0;
      nsamp <= 6'h00;
      trip_time <= 32'h00000000;
      for (int p = 0; p < 3; p++)
      begin
        peak[p] <= CUR_RST;
        last_i[p] <= CUR_RST;
      end
    end
    else
    begin
      cap_done <= 1'b0;
      if (!cap_busy)
      begin
        if (trip_s2 && !trip_d)
        begin
          cap_busy <= 1'b1;
          tick <= '0;
          nsamp <= 6'h00;
          trip_time <= TIME_I;
          for (int p = 0; p < 3; p++)
            peak[p] <= mag[p];
        end
      end
      else if (tick == TICK_W'(SAMPLE_CYC - 1))
      begin
        tick <= '0;
        nsamp <= nsamp + 6'h01;
        if (nsamp == 6'(CAPTURE_SAMPLES - 1))
        begin
          cap_busy <= 1'b0;
          cap_done <= 1'b1;
          for (int p = 0; p < 3; p++)
            last_i[p] <= peak[p];
        end
        else
        begin
          for (int p = 0; p < 3; p++)
            peak[p] <= next_peak[p];
          if (&low)
          begin
            cap_busy <= 1'b0;
            cap_done <= 1'b1;
            for (int p = 0; p < 3; p++)
              last_i[p] <= next_peak[p];
          end
        end
      end
      else
        tick <= tick + TICK_W'(1);
    end
  end

  // ----------------------------------------
  // shared divider
  // ----------------------------------------
  logic div_go;
  logic div_done;
  logic [31:0] div_n;
  logic [31:0] div_d;
  logic [31:0] quo;
  logic [31:0] rem;
  logic [5:0] dcnt;
  logic [32:0] dtrial;

  assign dtrial = {rem, quo[31]} - {1'b0, div_d};

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      quo <= 32'h00000000;
      rem <= 32'h00000000;
      dcnt <= 6'h00;
      div_done <= 1'b0;
    end
    else if (div_go)
    begin
      quo <= div_n;
      rem <= 32'h00000000;
      dcnt <= 6'h20;
      div_done <= 1'b0;
    end
    else if (dcnt != 6'h00)
    begin
      quo <= {quo[30:0], ~dtrial[32]};
      rem <= dtrial[32] ? {rem[30:0], quo[31]} : dtrial[31:0];
      dcnt <= dcnt - 6'h01;
      div_done <= dcnt == 6'h01;
    end
    else
      div_done <= 1'b0;
  end

  // ----------------------------------------
  // curve lookup
  // ----------------------------------------
  calc_state_e state;
  logic [2:0] ev;
  logic [CUR_W-1:0] item_cur;
  logic below;
  logic above;
  logic found;
  logic [2:0] seg;
  logic [2:0] seg_hi;
  logic [LOG_W-1:0] l_lo;
  logic [LOG_W-1:0] l_span;
  logic [LOG_W-1:0] l_off;
  logic [LOG_W-1:0] c_lo;
  logic [LOG_W-1:0] c_hi;
  logic signed [16:0] dlc;
  logic signed [34:0] prod;
  logic [16:0] lc;
  logic [31:0] c_exp;
  logic [CNT_W-1:0] c_interp;

  always_comb
  begin
    item_cur = (ev < 3'd3) ? last_i[ev[1:0]] : alarm_cur[ev[2]];
    below = item_cur <= curve_i[0];
    above = item_cur >= curve_i[NPOINT-1];
    seg = 3'd0;
    found = 1'b0;
    for (int k = 0; k < NPOINT - 1; k++)
    begin
      if (!found && item_cur <= curve_i[k+1])
      begin
        seg = 3'(k);
        found = 1'b1;
      end
    end
    seg_hi = seg + 3'd1;
    l_lo = log2f(curve_i[seg]);
    l_span = log2f(curve_i[seg_hi]) - l_lo;
    l_off = log2f(item_cur) - l_lo;
    c_lo = log2f(curve_c[seg]);
    c_hi = log2f(curve_c[seg_hi]);
    // log C = log Ck - n * (log I - log Ik), same as C = a / I^n
    dlc = $signed({1'b0, c_lo}) - $signed({1'b0, c_hi});
    prod = dlc * $signed({1'b0, quo[16:0]});
    lc = {1'b0, c_lo} - prod[32:16];
    c_exp = exp2f(lc[LOG_W-1:0]);
    c_interp = (|c_exp[31:CNT_W]) ? {CNT_W{1'b1}} : c_exp[CNT_W-1:0];
  end

  // ----------------------------------------
  // wear counters
  // ----------------------------------------
  logic [CNT_W-1:0] c_val [5];
  logic [CNT_W-1:0] cyc_left [NCNT];
  logic [CNT_W-1:0] dec;
  logic is_clear;
  logic ra;
  logic [1:0] rp;
  logic [2:0] cidx;
  logic trip_pend;
  logic clear_pend;
  logic [CNT_W-1:0] ca;
  logic [CNT_W-1:0] cp;
  logic [2:0] ev_next;
  calc_state_e ev_after;

  assign cidx = ra ? {1'b0, rp} + 3'd3 : {1'b0, rp};
  assign ca = c_val[ra ? 4 : 3];
  assign cp = c_val[rp];
  assign ev_next = ev + 3'd1;
  assign ev_after = (ev == 3'd4) ? (is_clear ? S_LOAD : S_RATIO) : S_EVAL;

  // a trip captured during a long calculation overwrites the stored
  // currents; the window is a few hundred cycles against 10 ms sampling
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      state <= S_IDLE;
      ev <= 3'd0;
      is_clear <= 1'b0;
      ra <= 1'b0;
      rp <= 2'd0;
      dec <= CNT_RST;
      div_go <= 1'b0;
      div_n <= 32'h00000000;
      div_d <= 32'h00000000;
      trip_pend <= 1'b0;
      clear_pend <= 1'b0;
      for (int j = 0; j < 5; j++)
        c_val[j] <= CNT_RST;
      for (int j = 0; j < NCNT; j++)
        cyc_left[j] <= CNT_RST;
    end
    else
    begin
      div_go <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (clear_pend)
          begin
            clear_pend <= 1'b0;
            is_clear <= 1'b1;
            ev <= 3'd3;
            state <= S_EVAL;
          end
          else if (trip_pend)
          begin
            trip_pend <= 1'b0;
            is_clear <= 1'b0;
            ev <= 3'd0;
            state <= S_EVAL;
          end
        end
        S_EVAL:
        begin
          if (below || above || l_span == 16'h0000)
          begin
            c_val[ev] <= below ? curve_c[0] : above ? curve_c[NPOINT-1] : curve_c[seg_hi];
            ev <= ev_next;
            state <= ev_after;
          end
          else
          begin
            div_n <= {l_off, 16'h0000};
            div_d <= {16'h0000, l_span};
            div_go <= 1'b1;
            state <= S_IDIV;
          end
        end
        S_IDIV:
        begin
          if (div_done)
            state <= S_IFIN;
        end
        S_IFIN:
        begin
          c_val[ev] <= c_interp;
          ev <= ev_next;
          state <= ev_after;
        end
        S_LOAD:
        begin
          for (int j = 0; j < NCNT; j++)
            cyc_left[j] <= c_val[3 + j / 3];
          state <= S_IDLE;
        end
        S_RATIO:
        begin
          if (last_i[rp] < alarm_cur[ra])
          begin
            dec <= 20'h00001;
            state <= S_RFIN;
          end
          else if (cp == CNT_RST)
          begin
            dec <= {CNT_W{1'b1}};
            state <= S_RFIN;
          end
          else
          begin
            div_n <= {11'h000, ca, 1'b0} + {12'h000, cp};
            div_d <= {11'h000, cp, 1'b0};
            div_go <= 1'b1;
            state <= S_RDIV;
          end
        end
        S_RDIV:
        begin
          if (div_done)
          begin
            dec <= (|quo[31:CNT_W]) ? {CNT_W{1'b1}} : quo[CNT_W-1:0];
            state <= S_RFIN;
          end
        end
        S_RFIN:
        begin
          cyc_left[cidx] <= (cyc_left[cidx] > dec) ? cyc_left[cidx] - dec : CNT_RST;
          if (rp == 2'd2)
          begin
            rp <= 2'd0;
            ra <= ~ra;
            if (ra)
              state <= S_IDLE;
            else
              state <= S_RATIO;
          end
          else
          begin
            rp <= rp + 2'd1;
            state <= S_RATIO;
          end
        end
        default: state <= S_IDLE;
      endcase
      if (cap_done)
        trip_pend <= 1'b1;
      if (clear_cmd)
        clear_pend <= 1'b1;
    end
  end

  // ----------------------------------------
  // alarms, events and interrupt
  // ----------------------------------------
  logic [1:0] alarm_lvl;
  logic [3:0] ev_raw;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_clr;

  generate
    for (genvar a = 0; a < 2; a++)
    begin : g_alarm
      assign alarm_lvl[a] = (cyc_left[3*a] < alarm_lim[a]) | (cyc_left[3*a+1] < alarm_lim[a])
        | (cyc_left[3*a+2] < alarm_lim[a]);
      assign ev_raw[2*a] = alarm_lvl[a] & ~ALARM_O[a];
      assign ev_raw[2*a+1] = ~alarm_lvl[a] & ALARM_O[a];
    end
  endgenerate

  assign irq_clr = (WR_I && ADDR_I == A_IRQ_CLR) ? WDATA_I[IRQ_W-1:0] : 5'h00;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      ALARM_O <= 2'b00;
      EVENT_O <= 4'h0;
      irq_stat <= 5'h00;
      IRQ_O <= 1'b0;
    end
    else
    begin
      ALARM_O <= alarm_lvl;
      EVENT_O <= ev_raw & ev_en;
      // set wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~irq_clr) | {cap_done, ev_raw & ev_en};
      IRQ_O <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [31:0] rd_val;

  always_comb
  begin
    rd_val = 32'h00000000;
    case (ADDR_I)
      A_CTRL: rd_val = {28'h0000000, ev_en};
      A_AL1_CUR: rd_val = {12'h000, alarm_cur[0]};
      A_AL1_LIM: rd_val = {12'h000, alarm_lim[0]};
      A_AL2_CUR: rd_val = {12'h000, alarm_cur[1]};
      A_AL2_LIM: rd_val = {12'h000, alarm_lim[1]};
      A_STATUS: rd_val = {28'h0000000, state != S_IDLE, cap_busy, ALARM_O};
      A_IRQ_STAT: rd_val = {27'h0000000, irq_stat};
      A_IRQ_EN: rd_val = {27'h0000000, irq_en};
      A_TRIP_TIME: rd_val = trip_time;
      default:
      begin
        if (ADDR_I[7:4] == A_LAST_I[7:4] && ADDR_I[3:0] >= 4'h8)
          rd_val = {12'h000, last_i[2'(ADDR_I[3:2] - 2'd2)]};
        else if (ADDR_I >= A_LAST_I + 8'h08 && ADDR_I < A_LAST_I + 8'h0c)
          rd_val = {12'h000, last_i[2]};
        else if (ADDR_I >= A_CYC_LEFT && ADDR_I < A_CYC_LEFT + 8'h18)
          rd_val = {12'h000, cyc_left[3'(ADDR_I[4:2])]};
        else if (ADDR_I[7:6] == A_CURVE[7:6])
          rd_val = ADDR_I[2] ? {12'h000, curve_c[ADDR_I[5:3]]} : {12'h000, curve_i[ADDR_I[5:3]]};
      end
    endcase
    if (ADDR_I[1:0] != 2'b00)
      rd_val = 32'h00000000;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      RDATA_O <= 32'h00000000;
    else
      RDATA_O <= RD_I ? rd_val : 32'h00000000;
  end

endmodule
`default_nettype wire

// ===== verification/wear_checker.sv
// port checker for the breaker wear monitor
// assumes one clock domain and a synchronous active high reset
`default_nettype none
module wear_checker
  import wear_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] ALARM_O,
  input wire logic [3:0] EVENT_O,
  input wire logic IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SRST_I);

  a_reset_quiet: assert property ($fell(SRST_I) |-> ALARM_O == 2'h0 && EVENT_O == 4'h0 && !IRQ_O)
    else $error("outputs busy right after reset");
  a_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data outside its answer cycle");
  a_odd_read: assert property (RD_I && ADDR_I[1:0] != 2'h0 |=> RDATA_O == 32'h0)
    else $error("unaligned read returned data");
  a_irq_masked: assert property (WR_I && ADDR_I == A_IRQ_EN && WDATA_I[IRQ_W-1:0] == 5'h00 |-> ##2 !IRQ_O)
    else $error("interrupt stays up while masked");
  a_event_pulse: assert property (EVENT_O != 4'h0 |=> (EVENT_O & $past(EVENT_O)) == 4'h0)
    else $error("event longer than one cycle");
  a_one_on: assert property (EVENT_O[0] |-> ALARM_O[0] && !$past(ALARM_O[0], 2))
    else $error("alarm one on event without alarm rise");
  a_two_on: assert property (EVENT_O[2] |-> ALARM_O[1] && !$past(ALARM_O[1], 2))
    else $error("alarm two on event without alarm rise");
  a_two_off: assert property (EVENT_O[3] |-> !ALARM_O[1] && $past(ALARM_O[1], 2))
    else $error("alarm two off event without alarm fall");
endmodule

bind breaker_wear_function wear_checker u_wear_checker (
  .SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .ALARM_O(ALARM_O), .EVENT_O(EVENT_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// ===== verification/trip_source.sv
// model of the supervised trip output and the phase magnitude front end
// assumes one fire_i pulse per trip and a 20 cycle sample interval
`default_nettype none
module trip_source
  import wear_pkg::*;
(
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic hold_i,
  output logic trip_o,
  output phase_mag_s mag_o
);
  // ------------
  // trip profile
  // ------------
  timeunit 1ns;
  timeprecision 1ps;
  int n = 2000;
  logic held = 1'b0;

  // steps change midway between samples; a short spike sits off the sample points
  function automatic phase_mag_s prof(input int k, input logic h);
    phase_mag_s m;
    int s;
    m = '0;
    s = (k + 10) / 20;
    if (h)
    begin
      if (k < 1100)
        m = '{c: 20'h00080, b: 20'h00080, a: 20'h00080};
    end
    else if (k >= 12 && k <= 14)
      m = '{c: 20'h02000, b: 20'h02000, a: 20'h02000};
    else if (s == 0)
      m = '{c: 20'h00040, b: 20'h00800, a: 20'h00200};
    else if (s == 1)
      m = '{c: 20'h00040, b: 20'h01000, a: 20'h00400};
    else if (s == 2)
      m = '{c: 20'h00020, b: 20'h00800, a: 20'h00200};
    return m;
  endfunction

  always @(posedge clk_i)
  begin
    if (fire_i)
    begin
      n <= 0;
      held <= hold_i;
    end
    else if (n < 2000)
      n <= n + 1;
  end

  assign trip_o = (n < 8);
  always_comb mag_o = prof(n, held);
endmodule
`default_nettype wire

// ===== verification/breaker_wear_function_bench.sv
// self-checking bench for the breaker wear monitor
// assumes the package constants and the trip_source front end model
`default_nettype none
module breaker_wear_function_bench
  import wear_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // -------
  // harness
  // -------
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic fire = 1'b0;
  logic hold = 1'b0;
  logic unlock = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] tstamp = 32'h0;
  logic trip;
  phase_mag_s mag;
  logic [31:0] rdata;
  logic [1:0] alarm;
  logic [3:0] evt;
  logic irq;
  logic [3:0] ev_seen = 4'h0;
  logic [31:0] rel[6];
  logic [31:0] base[6];
  logic [31:0] dec[6] = '{32'h8, 32'h20, 32'h1, 32'h1, 32'h4, 32'h1};
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  trip_source u_front (.clk_i(sys_clk), .fire_i(fire), .hold_i(hold), .trip_o(trip), .mag_o(mag));

  breaker_wear_function #(.SAMPLE_CYC(20)) DUT (
    .SYS_CLK_I(sys_clk), .SRST_I(srst), .TRIP_I(trip), .PHASE_MAG_I(mag), .TIME_I(tstamp),
    .UNLOCK_I(unlock), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .ALARM_O(alarm), .EVENT_O(evt), .IRQ_O(irq)
  );

  // the ceiling is several times the expected run
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    ev_seen <= ev_seen | evt;
    if (cyc == 20000)
    begin
      fail_count++;
      $display("mismatch timeout expected done seen hang");
      test_done();
    end
  end

  // -------
  // helpers
  // -------
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd32(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    v = rdata;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd32(a, v);
    chk(nm, e, v);
  endtask

  task automatic rd_cnt(output logic [31:0] c[6]);
    for (int i = 0; i < NCNT; i++)
      rd32(A_CYC_LEFT + 8'(4 * i), c[i]);
  endtask

  task automatic calc_wait();
    logic [31:0] v;
    v = 32'hc;
    repeat (4) @(posedge sys_clk);
    while (v[3:2] != 2'h0 && cyc < 19000)
      rd32(A_STATUS, v);
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic trip_run(input logic h, output int d);
    logic [31:0] v;
    int t0;
    hold <= h;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    t0 = cyc;
    v = 32'h0;
    while (v[IRQ_TRIP_BIT] !== 1'b1 && cyc - t0 < 2000)
      rd32(A_IRQ_STAT, v);
    d = cyc - t0;
    calc_wait();
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq level", 32'(e), 32'(irq));
  endtask

  // ---------
  // scenarios
  // ---------
  task automatic t_regs();
    rdc("irq enable reset", A_IRQ_EN, 32'h0);
    wr32(A_AL1_CUR, 32'habc);
    rdc("locked write", A_AL1_CUR, 32'h0);
    unlock <= 1'b1;
    wr32(A_AL1_CUR, 32'habc);
    rdc("alarm one current", A_AL1_CUR, 32'habc);
    rdc("unaligned read", A_AL1_CUR + 8'h01, 32'h0);
    rdc("unmapped read", 8'h3c, 32'h0);
  endtask

  // powers of two keep the log curve exact at the points
  task automatic t_setup();
    for (int k = 0; k < NPOINT; k++)
    begin
      wr32(A_CURVE + 8'(8 * k), 32'(128 << k));
      wr32(A_CURVE + 8'(8 * k + 4), 32'(4096 >> k));
    end
    wr32(A_AL1_CUR, 32'h80);
    wr32(A_AL2_CUR, 32'h400);
    wr32(A_CTRL, 32'h10f);
    calc_wait();
    rel = '{32'h1000, 32'h1000, 32'h1000, 32'h200, 32'h200, 32'h200};
    rd_cnt(base);
    for (int i = 0; i < NCNT; i++)
      chk("reload", rel[i], base[i]);
    chk("alarms idle", 32'h0, 32'(alarm));
    base = rel;
  endtask

  task automatic t_trip();
    logic [31:0] l1;
    logic [31:0] l2;
    logic [31:0] c[6];
    int d;
    l1 = 32'hfffff;
    l2 = 32'hfffff;
    for (int i = 0; i < 3; i++)
    begin
      if (base[i] - dec[i] < l1)
        l1 = base[i] - dec[i];
      if (base[i + 3] - dec[i + 3] < l2)
        l2 = base[i + 3] - dec[i + 3];
    end
    wr32(A_AL1_LIM, l1 + 32'h1);
    wr32(A_AL2_LIM, l2);
    tstamp <= 32'h00012345;
    trip_run(1'b0, d);
    chk("quarter stop", 32'h1, 32'(d > 40 && d < 100));
    rdc("peak phase a", A_LAST_I, 32'h400);
    rdc("peak phase b", A_LAST_I + 8'h04, 32'h1000);
    rdc("peak phase c", A_LAST_I + 8'h08, 32'h40);
    rdc("trip time", A_TRIP_TIME, 32'h00012345);
    rd_cnt(c);
    for (int i = 0; i < NCNT; i++)
    begin
      base[i] = base[i] - dec[i];
      chk("ratio decrement", base[i], c[i]);
    end
    chk("alarm one only", 32'h1, 32'(alarm));
    chk("on event", 32'h1, 32'(ev_seen));
  endtask

  task automatic t_irq();
    rdc("irq status", A_IRQ_STAT, 32'h11);
    wr32(A_IRQ_EN, 32'h10);
    irq_is(1'b1);
    wr32(A_IRQ_EN, 32'h0);
    irq_is(1'b0);
    wr32(A_IRQ_EN, 32'h10);
    irq_is(1'b1);
    wr32(A_IRQ_CLR, 32'h1f);
    irq_is(1'b0);
    rdc("irq cleared", A_IRQ_STAT, 32'h0);
  endtask

  task automatic t_window();
    logic [31:0] c[6];
    int d;
    tstamp <= 32'h00020000;
    trip_run(1'b1, d);
    chk("window stop", 32'h1, 32'(d > 960 && d < 1030));
    rdc("held peak", A_LAST_I, 32'h80);
    rdc("second time", A_TRIP_TIME, 32'h00020000);
    rd_cnt(c);
    for (int i = 0; i < NCNT; i++)
    begin
      base[i] = base[i] - 32'h1;
      chk("unit decrement", base[i], c[i]);
    end
    chk("both alarms", 32'h3, 32'(alarm));
    chk("two on event", 32'h5, 32'(ev_seen));
  endtask

  task automatic t_clear();
    logic [31:0] c[6];
    unlock <= 1'b0;
    wr32(A_CTRL, 32'h108);
    calc_wait();
    rd_cnt(c);
    chk("locked clear", base[0], c[0]);
    unlock <= 1'b1;
    wr32(A_CTRL, 32'h108);
    calc_wait();
    rd_cnt(c);
    for (int i = 0; i < NCNT; i++)
      chk("cleared counter", rel[i], c[i]);
    chk("alarms released", 32'h0, 32'(alarm));
    chk("gated off events", 32'hd, 32'(ev_seen));
    rdc("clear self resets", A_CTRL, 32'h8);
  endtask

  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_setup();
    t_trip();
    t_irq();
    t_window();
    t_clear();
    test_done();
  end
endmodule
`default_nettype wire
